//--- obp_host.sv
`default_nettype none
// Contract
// - Target software sets control space enable before download to enter user program mode.
// - Both sides use eight data bits, one stop bit, no parity.
// - Host checks zero byte, sends 0x55; on failure resets and repeats.
// - Host transmits only at 4800, 9600 or 19200 bits per second.
// - Target clock 4-20 MHz, or 8-20 MHz for the highest rate.
// - Program records end with an all-ones address, returning to command wait.
// - Erase block numbers end with 0xFF, returning to command wait.
// - No reset during programming; after one, hold reset at least 100 us.
// - Partial blocks are padded to 128 bytes, preferably with 0xFF.
// - Download request write executes from on-chip RAM.
module obp_host #(
  parameter int unsigned RESET_HOLD_CYCLES = obp_pkg::RESET_HOLD_CYC,
  parameter int unsigned SYNC_TRIES = obp_pkg::SYNC_TRIES_DEF,
  parameter int unsigned RESTARTS = obp_pkg::RESTARTS_DEF,
  parameter int unsigned CLOCK_HZ = obp_pkg::CLK_HZ
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output obp_pkg::obp_pins_type target_pins,
  output logic txd,
  input wire logic rxd
);
  import obp_pkg::*;

  logic act_q, act_d, wr_q, wr_d, hready_q, hready_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;
  obp_state_type state_q, state_d;
  obp_pins_type pins_q, pins_d;
  obp_err_type err_q, err_d;
  logic [1:0] baud_q, baud_d;
  logic clk_fast_q, clk_fast_d, user_q, user_d, pad_q, pad_d;
  logic [31:0] cnt_q, cnt_d;
  logic [1:0] restarts_q, restarts_d;
  logic [2:0] term_q, term_d;
  logic [BLOCK_BITS-1:0] blk_q, blk_d;
  logic [7:0] txh_q, txh_d, rxh_q, rxh_d;
  logic txh_vld_q, txh_vld_d, rxh_vld_q, rxh_vld_d;
  logic tx_go, tx_busy, rx_valid, rx_ferr, wen, pop, addr_ph;
  logic [7:0] tx_byte, rx_byte;

  assign hreadyout = hready_q;
  assign hrdata = rdata_q;
  assign hresp = 1'b0;
  assign target_pins = pins_q;
  assign addr_ph = hsel && hready && htrans[1];
  assign wen = act_q && wr_q;
  assign pop = addr_ph && !hwrite && (haddr[7:0] == REG_RXDATA);

  obp_uart u_uart (
    .mclk(mclk),
    .srst(srst),
    .div(baud_div(baud_q, CLOCK_HZ)),
    .tx_start(tx_go),
    .tx_byte(tx_byte),
    .tx_busy(tx_busy),
    .txd(txd),
    .rxd(rxd),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .rx_frame_err(rx_ferr)
  );

  // Zero-wait slave: read data is muxed at the address phase and registered
  always_comb
  begin
    act_d = addr_ph;
    wr_d = hwrite;
    addr_d = haddr[7:0];
    hready_d = 1'b1;
    rdata_d = rdata_q;
    if (addr_ph && !hwrite)
    begin
      case (haddr[7:0])
        REG_CTRL: rdata_d = {25'h0000000, clk_fast_q, baud_q, 4'h0};
        REG_STATUS: rdata_d = {9'h000, blk_q, 3'h0, err_q, 1'b0, tx_busy, rxh_vld_q, !txh_vld_q, 1'b0, state_q};
        REG_TXDATA: rdata_d = {24'h000000, txh_q};
        REG_RXDATA: rdata_d = {24'h000000, rxh_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hready_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      act_q <= act_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      hready_q <= hready_d;
      rdata_q <= rdata_d;
    end
  end

  always_comb
  begin
    state_d = state_q;
    pins_d = pins_q;
    err_d = err_q;
    baud_d = baud_q;
    clk_fast_d = clk_fast_q;
    user_d = user_q;
    pad_d = pad_q;
    cnt_d = cnt_q;
    restarts_d = restarts_q;
    term_d = term_q;
    blk_d = blk_q;
    txh_d = txh_q;
    txh_vld_d = txh_vld_q;
    rxh_d = rxh_q;
    rxh_vld_d = rxh_vld_q;
    tx_go = 1'b0;
    tx_byte = txh_q;
    if (wen && addr_q == REG_STATUS)
      err_d = err_q & ~obp_err_type'(hwdata[ST_ERR_LO +: 5]);
    if (pop)
      rxh_vld_d = 1'b0;
    case (state_q)
      ST_RST_HOLD:
      begin
        cnt_d = cnt_q + 32'h00000001;
        // Long hold also covers the case of an interrupted program/erase
        if (cnt_q >= RESET_HOLD_CYCLES - 1)
        begin
          pins_d.reset_n = 1'b1;
          cnt_d = 32'h00000000;
          state_d = user_q ? ST_USER : ST_SYNC;
        end
      end
      ST_SYNC:
      begin
        if (rx_valid && rx_byte == SYNC_BYTE)
          state_d = ST_ACK;
        else if (!tx_busy && cnt_q < SYNC_TRIES)
        begin
          tx_go = 1'b1;
          tx_byte = SYNC_BYTE;
          cnt_d = cnt_q + 32'h00000001;
        end
        else if (!tx_busy || rx_valid || rx_ferr)
        begin
          // No clean zero byte back: restart through reset, or stop in ST_FAIL after RESTARTS restarts
          cnt_d = 32'h00000000;
          pins_d.reset_n = 1'b0;
          if (restarts_q == 2'(RESTARTS))
          begin
            err_d.sync_fail = 1'b1;
            state_d = ST_FAIL;
          end
          else
          begin
            restarts_d = restarts_q + 2'h1;
            state_d = ST_RST_HOLD;
          end
        end
      end
      ST_ACK:
      begin
        if (!tx_busy)
        begin
          tx_go = 1'b1;
          tx_byte = ACK_BYTE;
          state_d = ST_READY;
        end
      end
      ST_READY, ST_USER:
      begin
        if (!tx_busy)
        begin
          if (term_q != 3'h0)
          begin
            tx_go = 1'b1;
            tx_byte = END_BYTE;
            term_d = term_q - 3'h1;
          end
          else if (pad_q)
          begin
            if (blk_q == '0)
              pad_d = 1'b0;
            else
            begin
              tx_go = 1'b1;
              tx_byte = FILL_BYTE;
              blk_d = blk_q + 1'b1;
            end
          end
          else if (txh_vld_q)
          begin
            tx_go = 1'b1;
            txh_vld_d = 1'b0;
            blk_d = blk_q + 1'b1;
          end
        end
        if (rx_valid)
        begin
          if (rxh_vld_q && !pop)
            err_d.rx_overrun = 1'b1;
          rxh_d = rx_byte;
          rxh_vld_d = 1'b1;
        end
        if (rx_ferr)
          err_d.frame_err = 1'b1;
      end
      ST_IDLE, ST_FAIL:
      begin
        cnt_d = 32'h00000000;
      end
      default:
      begin
        state_d = ST_IDLE;
        pins_d = PINS_IDLE;
      end
    endcase
    if (wen && addr_q == REG_TXDATA)
    begin
      if (txh_vld_q && !(tx_go && txh_vld_d == 1'b0))
        err_d.tx_overrun = 1'b1;
      else
      begin
        txh_d = hwdata[7:0];
        txh_vld_d = 1'b1;
      end
    end
    if (wen && addr_q == REG_CTRL)
    begin
      baud_d = hwdata[CTRL_BAUD_LO +: 2];
      clk_fast_d = hwdata[CTRL_CLK_FAST];
      if (hwdata[CTRL_END_PROG])
      begin
        term_d = PROG_END_LEN;
        blk_d = '0;
      end
      if (hwdata[CTRL_END_ERASE])
      begin
        term_d = ERASE_END_LEN;
        blk_d = '0;
      end
      if (hwdata[CTRL_PAD])
        pad_d = 1'b1;
      if (hwdata[CTRL_RELEASE])
      begin
        state_d = ST_IDLE;
        pins_d = PINS_IDLE;
      end
      else if (hwdata[CTRL_BOOT] || hwdata[CTRL_USER])
      begin
        // Highest rate is only safe when software vouches for a fast target clock
        if (hwdata[CTRL_BOOT] && hwdata[CTRL_BAUD_LO +: 2] >= BAUD_HIGH_SEL && !hwdata[CTRL_CLK_FAST])
          err_d.rate_refused = 1'b1;
        else
        begin
          user_d = !hwdata[CTRL_BOOT];
          // Boot pins keep the interrupt pin inactive as well
          pins_d = hwdata[CTRL_BOOT] ? PINS_BOOT : PINS_USER;
          state_d = ST_RST_HOLD;
          cnt_d = 32'h00000000;
          restarts_d = 2'h0;
          term_d = 3'h0;
          pad_d = 1'b0;
          blk_d = '0;
          txh_vld_d = 1'b0;
          rxh_vld_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_q <= ST_IDLE;
      pins_q <= PINS_IDLE;
      err_q <= '0;
      baud_q <= BAUD_RESET;
      clk_fast_q <= 1'b0;
      user_q <= 1'b0;
      pad_q <= 1'b0;
      cnt_q <= 32'h00000000;
      restarts_q <= 2'h0;
      term_q <= 3'h0;
      blk_q <= '0;
      txh_q <= 8'h00;
      txh_vld_q <= 1'b0;
      rxh_q <= 8'h00;
      rxh_vld_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pins_q <= pins_d;
      err_q <= err_d;
      baud_q <= baud_d;
      clk_fast_q <= clk_fast_d;
      user_q <= user_d;
      pad_q <= pad_d;
      cnt_q <= cnt_d;
      restarts_q <= restarts_d;
      term_q <= term_d;
      blk_q <= blk_d;
      txh_q <= txh_d;
      txh_vld_q <= txh_vld_d;
      rxh_q <= rxh_d;
      rxh_vld_q <= rxh_vld_d;
    end
  end
endmodule : obp_host
`default_nettype wire

//--- obp_host_assertions.sv
`default_nettype none
module obp_host_assertions #(
  parameter int unsigned RESET_HOLD_CYCLES = 20,
  parameter int unsigned CLOCK_HZ = obp_pkg::CLK_HZ
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire obp_pkg::obp_pins_type target_pins,
  input wire logic txd,
  input wire logic rxd
);
  import obp_pkg::*;
  localparam int unsigned MIN_BIT = (CLOCK_HZ + BPS_HIGH / 2) / BPS_HIGH;
  logic [31:0] rlow_q, rlow_d, tlow_q, tlow_d;
  logic cw_q, cw_d;
  logic boot_go, too_fast;
  assign boot_go = cw_q && hwdata[0] && !hwdata[1] && !hwdata[2];
  assign too_fast = hwdata[5] && !hwdata[6];
  always_comb
  begin
    rlow_d = target_pins.reset_n ? 32'h0 : rlow_q + 32'h1;
    tlow_d = txd ? 32'h0 : tlow_q + 32'h1;
    cw_d = hsel && hready && htrans[1] && hwrite && (haddr[7:0] == REG_CTRL);
  end
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      rlow_q <= 32'h0;
      tlow_q <= 32'h0;
      cw_q <= 1'b0;
    end
    else
    begin
      rlow_q <= rlow_d;
      tlow_q <= tlow_d;
      cw_q <= cw_d;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  a_pins_reset: assert property (disable iff (1'b0) srst |=> target_pins == PINS_IDLE)
    else $error("pins not idle after reset");
  a_nmi_high: assert property (
    target_pins.flash_write_enable && target_pins.mode_select_pin_2 |-> target_pins.nmi_level)
    else $error("interrupt pin active in boot");
  // Idle time before a start also counts, so only a floor
  a_hold_min: assert property ($rose(target_pins.reset_n) |-> rlow_q >= RESET_HOLD_CYCLES)
    else $error("target reset too short");
  a_bit_min: assert property ($rose(txd) |-> tlow_q >= MIN_BIT)
    else $error("serial low run shorter than a bit");
  a_boot_pins: assert property (
    boot_go && !too_fast |=> target_pins[5:2] == 4'b1100 && !target_pins.reset_n)
    else $error("boot pins wrong");
  a_user_pins: assert property (
    cw_q && hwdata[1] && !hwdata[0] && !hwdata[2] |=> target_pins[5:1] == 5'b10101)
    else $error("user program pins wrong");
  a_release_idle: assert property (cw_q && hwdata[2] |=> target_pins == PINS_IDLE)
    else $error("release left pins driven");
  a_rate_refused: assert property (
    boot_go && too_fast && target_pins == PINS_IDLE |=> $stable(target_pins))
    else $error("fast rate accepted on slow clock");
endmodule : obp_host_assertions
bind obp_host obp_host_assertions #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES), .CLOCK_HZ(CLOCK_HZ)) u_chk (
  .mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .target_pins(target_pins), .txd(txd), .rxd(rxd));
`default_nettype wire

//--- obp_pkg.sv
`default_nettype none
package obp_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned RESET_HOLD_US = 100;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ;
  localparam int unsigned SYNC_TRIES_DEF = 64;
  localparam int unsigned RESTARTS_DEF = 3;
  localparam int unsigned BPS_LOW = 4800;
  localparam int unsigned BPS_MID = 9600;
  localparam int unsigned BPS_HIGH = 19200;
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] ACK_BYTE = 8'h55;
  localparam logic [7:0] END_BYTE = 8'hff;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [2:0] PROG_END_LEN = 3'h4;
  localparam logic [2:0] ERASE_END_LEN = 3'h1;
  localparam int unsigned BLOCK_BITS = 7;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0c;
  localparam int CTRL_BOOT = 0;
  localparam int CTRL_USER = 1;
  localparam int CTRL_RELEASE = 2;
  localparam int CTRL_BAUD_LO = 4;
  localparam int CTRL_CLK_FAST = 6;
  localparam int CTRL_END_PROG = 8;
  localparam int CTRL_END_ERASE = 9;
  localparam int CTRL_PAD = 10;
  localparam int ST_TX_READY = 4;
  localparam int ST_RX_VALID = 5;
  localparam int ST_TX_BUSY = 6;
  localparam int ST_ERR_LO = 8;
  localparam int ST_BLK_LO = 16;
  localparam logic [1:0] BAUD_RESET = 2'h0;
  localparam logic [1:0] BAUD_HIGH_SEL = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RST_HOLD = 3'h1,
    ST_SYNC = 3'h3,
    ST_ACK = 3'h2,
    ST_READY = 3'h6,
    ST_USER = 3'h7,
    ST_FAIL = 3'h4
  } obp_state_type;

  typedef struct packed {
    logic flash_write_enable;
    logic mode_select_pin_2;
    logic mode_select_pin_1;
    logic mode_select_pin_0;
    logic nmi_level;
    logic reset_n;
  } obp_pins_type;

  typedef struct packed {
    logic frame_err;
    logic rx_overrun;
    logic tx_overrun;
    logic rate_refused;
    logic sync_fail;
  } obp_err_type;

  localparam obp_pins_type PINS_IDLE = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  localparam obp_pins_type PINS_BOOT = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  localparam obp_pins_type PINS_USER = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  function automatic logic [15:0] baud_div(input logic [1:0] sel, input int unsigned clk_hz);
    int unsigned bps;
    bps = (sel == 2'h0) ? BPS_LOW : (sel == 2'h1) ? BPS_MID : BPS_HIGH;
    return 16'((clk_hz + bps / 2) / bps);
  endfunction : baud_div
endpackage : obp_pkg
`default_nettype wire

//--- obp_target_model.sv
`default_nettype none
module obp_target_model (
  input wire logic mclk,
  input wire obp_pkg::obp_pins_type target_pins,
  input wire logic host_txd,
  output logic dev_txd,
  output logic got_valid,
  output logic [7:0] got_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic boot, seen;
  int bit_cyc, low;
  // Interrupt level not decoded: boot mode takes no interrupts
  assign boot = target_pins[5:2] == 4'b1100 && target_pins.reset_n;
  task automatic send(input logic [7:0] d);
    logic [9:0] fr;
    fr = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      dev_txd <= fr[i];
      repeat (bit_cyc) @(posedge mclk);
    end
  endtask : send
  task automatic listen;
    logic [7:0] d;
    while (boot)
    begin
      @(posedge mclk);
      if (host_txd === 1'b0)
      begin
        repeat (bit_cyc / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++)
        begin
          repeat (bit_cyc) @(posedge mclk);
          d[i] = host_txd;
        end
        repeat (bit_cyc) @(posedge mclk);
        // Zeros before the first other byte are still rate probes
        if (host_txd === 1'b1 && boot && (seen || d != 8'h00))
        begin
          seen = 1'b1;
          got_byte <= d;
          got_valid <= 1'b1;
          @(posedge mclk);
          got_valid <= 1'b0;
        end
      end
    end
  endtask : listen
  initial
  begin
    {dev_txd, got_valid, seen, got_byte} = {3'b100, 8'h00};
    forever
    begin
      low = 0;
      @(posedge mclk);
      while (boot && host_txd === 1'b0)
      begin
        @(posedge mclk);
        low++;
      end
      if (boot && low > 0)
      begin
        bit_cyc = low / 9;
        fork
          send(8'h00);
          listen;
        join
      end
    end
  end
endmodule : obp_target_model
`default_nettype wire

//--- obp_testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import obp_pkg::*;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} obp_exp_type;
  localparam int unsigned HOLD = 20;
  // Scaled clock figure keeps a bit time at ten cycles for a short run
  localparam int unsigned CLK_SCALED = 192_000;
  logic mclk, srst, hsel, hwrite, hready, hreadyout, hresp, txd, rxd, rd_q, got_valid;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] got_byte, b;
  obp_pins_type target_pins;
  obp_exp_type exp_q[$];
  int error_cnt = 0;
  int n_checks = 0;
  int seed = 32'habfdb72b;
  int n;
  assign hready = hreadyout;
  always #2.5 mclk = ~mclk;
  obp_host #(.RESET_HOLD_CYCLES(HOLD), .SYNC_TRIES(4), .RESTARTS(3), .CLOCK_HZ(CLK_SCALED)) uut (
    .mclk(mclk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .target_pins(target_pins), .txd(txd), .rxd(rxd));
  obp_target_model u_dev (.mclk(mclk), .target_pins(target_pins), .host_txd(txd), .dev_txd(rxd),
    .got_valid(got_valid), .got_byte(got_byte));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {hsel, hwrite, htrans, haddr} <= {1'b1, wr, 2'h2, 24'h0, a};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
  endtask : ahb
  task automatic note(input logic [31:0] v, input logic [31:0] m);
    exp_q.push_back('{v, m});
  endtask : note
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    note(v, m);
    ahb(1'b0, a, 32'h0);
  endtask : rd
  task automatic pins(input logic [5:0] v, input logic [5:0] m);
    @(negedge mclk);
    check({26'h0, target_pins & m}, {26'h0, v & m});
  endtask : pins
  task automatic wait_q;
    while (exp_q.size() != 0) @(posedge mclk);
  endtask : wait_q
  task automatic take(input logic [31:0] seen);
    obp_exp_type e;
    // An unexpected result meets an unknown and so always fails
    e = (exp_q.size() != 0) ? exp_q.pop_front() : '{32'hx, 32'hffffffff};
    check(seen & e.m, e.v & e.m);
  endtask : take
  always @(posedge mclk)
  begin
    if (rd_q === 1'b1) take(hrdata);
    if (got_valid === 1'b1) take({24'h0, got_byte});
    rd_q <= hsel && hready && htrans[1] && !hwrite;
  end
  initial
  begin
    {mclk, srst, hsel, hwrite, rd_q, hsize} = {5'b01000, 3'h2};
    {haddr, hwdata, htrans} = '0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    pins(PINS_IDLE, 6'h3f);
    check({31'h0, txd}, 32'h1);
    rd(REG_STATUS, 32'h0, 32'h1f07);
    rd(8'h10, 32'h0, 32'hffffffff);
    ahb(1'b1, REG_CTRL, 32'h21);
    pins(PINS_IDLE, 6'h3f);
    rd(REG_STATUS, 32'h200, 32'h200);
    ahb(1'b1, REG_STATUS, 32'h200);
    rd(REG_STATUS, 32'h0, 32'h1f00);
    for (int r = 0; r < 2; r++)
    begin
      ahb(1'b1, REG_CTRL, 32'h1 | (32'(r) << 4));
      pins(PINS_BOOT, 6'h3f);
      ahb(1'b1, REG_CTRL, 32'h4);
      pins(PINS_IDLE, 6'h3f);
    end
    ahb(1'b1, REG_CTRL, 32'h2);
    pins(PINS_USER, 6'h3e);
    ahb(1'b1, REG_CTRL, 32'h4);
    ahb(1'b1, REG_CTRL, 32'h61);
    pins(PINS_BOOT, 6'h3f);
    n = 0;
    while (target_pins.reset_n !== 1'b1 && n < 1000)
    begin
      @(negedge mclk);
      n++;
    end
    check({31'h0, n >= HOLD && n <= HOLD + 2}, 32'h1);
    rd(REG_CTRL, 32'h60, 32'h70);
    note(32'h55, 32'hff);
    wait_q;
    // Two bit times let the acknowledge stop bit finish
    repeat (20) @(posedge mclk);
    rd(REG_STATUS, 32'h6, 32'h7);
    b = 8'($random(seed));
    ahb(1'b1, REG_TXDATA, {24'h0, b});
    rd(REG_STATUS, 32'h10000, 32'h7f0000);
    note({24'h0, b}, 32'hff);
    wait_q;
    ahb(1'b1, REG_CTRL, 32'h460);
    for (int i = 0; i < 127; i++)
      note(32'hff, 32'hff);
    wait_q;
    rd(REG_STATUS, 32'h0, 32'h7f0000);
    ahb(1'b1, REG_CTRL, 32'h260);
    rd(REG_STATUS, 32'h0, 32'h7f0000);
    note(32'hff, 32'hff);
    wait_q;
    ahb(1'b1, REG_CTRL, 32'h160);
    repeat (4) note(32'hff, 32'hff);
    wait_q;
    print_verdict;
  end
  initial
  begin
    repeat (40000) @(posedge mclk);
    error_cnt++;
    print_verdict;
  end
endmodule : testbench
`default_nettype wire

//--- obp_uart.sv
`default_nettype none
module obp_uart (
  input wire logic mclk,
  input wire logic srst,
  input wire logic [15:0] div,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic txd,
  input wire logic rxd,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_frame_err
);
  import obp_pkg::*;

  logic tbusy_q, tbusy_d, txd_q, txd_d;
  logic [15:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
  logic [3:0] tbit_q, tbit_d, rbit_q, rbit_d;
  logic [9:0] tsh_q, tsh_d;
  logic rbusy_q, rbusy_d, rvld_q, rvld_d, rerr_q, rerr_d;
  logic [7:0] rsh_q, rsh_d;

  assign tx_busy = tbusy_q;
  assign txd = txd_q;
  assign rx_valid = rvld_q;
  assign rx_byte = rsh_q;
  assign rx_frame_err = rerr_q;

  // Ten bit times: start, eight data LSB first, one stop, no parity
  always_comb
  begin
    tbusy_d = tbusy_q;
    txd_d = txd_q;
    tcnt_d = tcnt_q;
    tbit_d = tbit_q;
    tsh_d = tsh_q;
    if (!tbusy_q)
    begin
      if (tx_start)
      begin
        tbusy_d = 1'b1;
        tsh_d = {1'b1, tx_byte, 1'b0};
        txd_d = 1'b0;
        tcnt_d = 16'h0000;
        tbit_d = 4'h0;
      end
    end
    else if (tcnt_q == div - 16'h0001)
    begin
      tcnt_d = 16'h0000;
      if (tbit_q == 4'h9)
      begin
        tbusy_d = 1'b0;
        txd_d = 1'b1;
      end
      else
      begin
        tsh_d = {1'b1, tsh_q[9:1]};
        txd_d = tsh_q[1];
        tbit_d = tbit_q + 4'h1;
      end
    end
    else
      tcnt_d = tcnt_q + 16'h0001;
  end

  // Sampling at mid-bit; a start bit that is gone by then is a glitch
  always_comb
  begin
    rbusy_d = rbusy_q;
    rcnt_d = rcnt_q;
    rbit_d = rbit_q;
    rsh_d = rsh_q;
    rvld_d = 1'b0;
    rerr_d = 1'b0;
    if (!rbusy_q)
    begin
      if (!rxd)
      begin
        rbusy_d = 1'b1;
        rcnt_d = {1'b0, div[15:1]};
        rbit_d = 4'h0;
      end
    end
    else if (rcnt_q == 16'h0000)
    begin
      rcnt_d = div - 16'h0001;
      rbit_d = rbit_q + 4'h1;
      if (rbit_q == 4'h0)
        rbusy_d = ~rxd;
      else if (rbit_q == 4'h9)
      begin
        rbusy_d = 1'b0;
        rvld_d = rxd;
        rerr_d = ~rxd;
      end
      else
        rsh_d = {rxd, rsh_q[7:1]};
    end
    else
      rcnt_d = rcnt_q - 16'h0001;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      tbusy_q <= 1'b0;
      txd_q <= 1'b1;
      tcnt_q <= 16'h0000;
      tbit_q <= 4'h0;
      tsh_q <= 10'h3ff;
      rbusy_q <= 1'b0;
      rcnt_q <= 16'h0000;
      rbit_q <= 4'h0;
      rsh_q <= 8'h00;
      rvld_q <= 1'b0;
      rerr_q <= 1'b0;
    end
    else
    begin
      tbusy_q <= tbusy_d;
      txd_q <= txd_d;
      tcnt_q <= tcnt_d;
      tbit_q <= tbit_d;
      tsh_q <= tsh_d;
      rbusy_q <= rbusy_d;
      rcnt_q <= rcnt_d;
      rbit_q <= rbit_d;
      rsh_q <= rsh_d;
      rvld_q <= rvld_d;
      rerr_q <= rerr_d;
    end
  end
endmodule : obp_uart
`default_nettype wire
